// >>> verif/qspi_flash_model.sv
// behavioural serial flash answering single, dual and quad reads
`timescale 1ns/1ps
module qspi_flash_model (
  // flash pins
  input  wire logic        sclk,
  input  wire logic        csN,
  input  wire logic        d1Out,
  input  wire logic        d1Oe,
  output logic      [3:0]  dIn,
  // set-up from the bench
  input  wire logic [2:0]  lanes,
  input  wire logic [5:0]  cmdBits,
  input  wire logic [63:0] pattern,
  input  wire logic [15:0] fallTotal,
  // what the flash saw on d1
  output logic      [31:0] cmdSeen,
  output logic      [5:0]  cmdCount
);
  int falls;
  int pos;

  // next lane group of the stream, first bit on the highest lane
  function automatic logic [3:0] groupAt(input int p);
    logic [3:0] v;
    v = 4'h0;
    for (int i = 0; i < int'(lanes); i++)
      v[int'(lanes) - 1 - i] = pattern[63 - ((p + i) % 64)];
    return v;
  endfunction : groupAt

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    dIn = 4'h5;
    cmdSeen = 32'h0;
    cmdCount = 6'h0;
  end

  always @(negedge csN) begin
    falls = 0;
    pos = 0;
    cmdSeen <= 32'h0;
    cmdCount <= 6'h0;
    if (cmdBits == 6'h0) begin
      dIn <= groupAt(0);
      pos = int'(lanes);
    end
  end

  // no pull on the lines: once deselected show the inverse, not the last bit
  always @(posedge csN) dIn <= ~dIn;

  // mode 0: command bits taken on the rising edge
  always @(posedge sclk) if (!csN && d1Oe) begin
    cmdSeen <= {cmdSeen[30:0], d1Out};
    cmdCount <= cmdCount + 6'h1;
  end

  // launch on the fall; the final group is held until deselect
  always @(negedge sclk) if (!csN) begin
    falls = falls + 1;
    if (falls >= int'(cmdBits) && falls < int'(fallTotal)) begin
      dIn <= groupAt(pos);
      pos = pos + int'(lanes);
    end
  end
endmodule : qspi_flash_model

// >>> verif/quad_spi_read_master_tb.sv
// self-checking bench of the quad serial read master against a flash model
`timescale 1ns/1ps
module quad_spi_read_master_tb;
  import qspi_read_pkg::*;
  logic                 ref_clk, rst_n, clkEn, start, wordIrqEn, frameIrqEn, rdReady;
  logic [7:0]           clockDivideSetting;
  logic [LEAD_W-1:0]    csLeadDelayField;
  logic [1:0]           laneMode;
  logic [WLEN_W-1:0]    wordLength;
  logic [NWORD_W-1:0]   frameWords;
  logic [CMD_W-1:0]     cmdWord;
  logic [CMD_CNT_W-1:0] cmdBits;
  logic                 busy, wordIrq, frameIrq, rdValid, sclk, csN, d1Out, d1Oe;
  logic [127:0]         rdData;
  logic [PIN_W-1:0]     dIn;
  logic [2:0]           lanes;
  logic [63:0]          pattern;
  logic [31:0]          cmdSeen;
  logic [5:0]           cmdCount;
  logic [15:0]          fallTotal;
  logic                 prevCs, prevSclk, prevOe, idleBad;
  int nErrors, numChecks, cyc, tCsFall, tCsRise, tOe, tFirst, tSecond, tLast;
  int nFalls, hiRun, hiLen, nWordIrq, nFrameIrq;

  quad_spi_read_master #(.DIV_W(8), .WORD_W(128), .FIFO_DEPTH(4)) quad_spi_read_master_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .start(start),
    .clockDivideSetting(clockDivideSetting), .csLeadDelayField(csLeadDelayField),
    .laneMode(laneMode), .wordLength(wordLength), .frameWords(frameWords),
    .cmdWord(cmdWord), .cmdBits(cmdBits), .wordIrqEn(wordIrqEn), .frameIrqEn(frameIrqEn),
    .busy(busy), .wordIrq(wordIrq), .frameIrq(frameIrq), .rdData(rdData),
    .rdValid(rdValid), .rdReady(rdReady), .sclk(sclk), .csN(csN), .d1Out(d1Out),
    .d1Oe(d1Oe), .dIn(dIn));

  qspi_flash_model qspi_flash_model_inst (
    .sclk(sclk), .csN(csN), .d1Out(d1Out), .d1Oe(d1Oe), .dIn(dIn), .lanes(lanes),
    .cmdBits(cmdBits), .pattern(pattern), .fallTotal(fallTotal), .cmdSeen(cmdSeen),
    .cmdCount(cmdCount));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // pre-edge values only, so the bench never races the design's updates
  always @(posedge ref_clk) begin
    cyc++;
    if (prevCs && !csN) tCsFall = cyc;
    if (!prevCs && csN) tCsRise = cyc;
    if (!prevOe && d1Oe && tOe < 0) tOe = cyc;
    if (sclk) hiRun++;
    if (prevSclk && !sclk) begin
      nFalls++;
      tLast = cyc;
      hiLen = hiRun;
      hiRun = 0;
      if (nFalls == 1) tFirst = cyc;
      if (nFalls == 2) tSecond = cyc;
    end
    if (csN && sclk) idleBad = 1'b1;
    if (wordIrq) nWordIrq++;
    if (frameIrq) nFrameIrq++;
    prevCs = csN;
    prevSclk = sclk;
    prevOe = d1Oe;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d mismatches %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  // sel high waits on busy, low on rdValid
  task automatic waitFor(input bit sel, input logic val);
    int guard;
    guard = 0;
    while ((sel ? busy : rdValid) !== val && guard < 5000) begin
      @(negedge ref_clk);
      guard++;
    end
    if (guard >= 5000) check("handshake wait", 1'b0, 1'b1);
  endtask : waitFor

  // one frame: d divide, l lead, m lane mode, wb word bits, nw words, cb command bits
  task automatic runFrame(input int d, l, m, wb, nw, cb, input bit stall);
    int p, h, ln;
    logic [127:0] expw;
    logic [63:0]  mk;
    p = (d == 0) ? 2 : d + 1;
    h = (d == 0) ? 1 : ((d % 2 == 1) ? (d + 1) / 2 : d / 2);
    ln = (m == 1) ? 2 : (m == 2) ? 4 : 1;
    clockDivideSetting = 8'(d);
    csLeadDelayField = 2'(l);
    laneMode = 2'(m);
    wordLength = 7'(wb - 1);
    frameWords = 12'(nw - 1);
    cmdBits = 6'(cb);
    lanes = 3'(ln);
    fallTotal = 16'(cb + nw * ((wb + ln - 1) / ln));
    wordIrqEn = d[0];
    frameIrqEn = ~d[0];
    nFalls = 0;
    tOe = -1;
    nWordIrq = 0;
    nFrameIrq = 0;
    idleBad = 1'b0;
    hiRun = 0;
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    repeat (3) @(negedge ref_clk);
    // a second start in mid-frame must change nothing
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    if (stall) begin
      repeat (1500) @(negedge ref_clk);
      check("stalled busy", busy, 1'b1);
      check("stalled sclk", sclk, 1'b0);
      check("full buffer valid", rdValid, 1'b1);
    end
    for (int j = 0; j < nw; j++) begin
      waitFor(1'b0, 1'b1);
      expw = '0;
      for (int b = 0; b < wb; b++) expw[wb - 1 - b] = pattern[63 - ((j * wb + b) % 64)];
      if (d >= 4) check("read word", rdData, expw);
      rdReady = 1'b1;
      @(negedge ref_clk);
      rdReady = 1'b0;
    end
    waitFor(1'b1, 1'b0);
    @(negedge ref_clk);
    mk = (64'h1 << cb) - 64'h1;
    check("lead time", tFirst - tCsFall, (l + 1) * p);
    check("period", tSecond - tFirst, p);
    check("high phase", hiLen, h);
    check("low phase", tSecond - tFirst - hiLen, p - h);
    check("tail time", tCsRise - tLast, 2 * p);
    check("fall count", nFalls, cb + nw * ((wb + ln - 1) / ln));
    check("idle low", idleBad, 1'b0);
    check("command count", cmdCount, cb);
    check("command word", cmdSeen, cmdWord & mk[31:0]);
    if (cb > 0) check("d1 early", tFirst - tOe, p);
    else check("d1 undriven", tOe, -1);
    check("word pulses", nWordIrq, d[0] ? nw : 0);
    check("frame pulses", nFrameIrq, d[0] ? 0 : 1);
    $display("frame done: divide %0d lead %0d mode %0d words %0d", d, l, m, nw);
  endtask : runFrame

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(40 * 60000);
    nErrors++;
    $display("watchdog expired");
    summarize();
  end

  initial begin
    {rst_n, start, wordIrqEn, frameIrqEn, rdReady} = 5'h00;
    clkEn = 1'b1;
    clockDivideSetting = 8'h00;
    csLeadDelayField = 2'h0;
    laneMode = 2'h0;
    wordLength = 7'h00;
    frameWords = 12'h000;
    cmdWord = 32'hC3A55A3C;
    cmdBits = 6'h00;
    lanes = 3'h1;
    fallTotal = 16'h0000;
    pattern = 64'hF0E1D2C3B4A59687;
    {prevCs, prevSclk, prevOe, idleBad} = 4'h8;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    runFrame(0, 0, 0, 8, 1, 8, 1'b0);
    runFrame(1, 3, 1, 8, 1, 0, 1'b0);
    runFrame(2, 1, 2, 16, 1, 4, 1'b0);
    runFrame(5, 2, 2, 16, 3, 8, 1'b0);
    runFrame(4, 0, 0, 8, 2, 8, 1'b0);
    runFrame(5, 1, 1, 12, 2, 32, 1'b0);
    runFrame(4, 3, 3, 1, 4, 2, 1'b0);
    runFrame(5, 0, 2, 128, 6, 0, 1'b1);
    summarize();
  end
endmodule : quad_spi_read_master_tb

// >>> verilog/qspi_read_pkg.sv
// package: constants, encodings and state codes of the quad serial read master
package qspi_read_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // field widths
  localparam int CMD_W      = 32;  // outgoing command word, msb first
  localparam int CMD_CNT_W  = 6;   // command bit count, 0..32
  localparam int WLEN_W     = 7;   // word length minus one, 1..128 bits
  localparam int NWORD_W    = 12;  // words per frame minus one, 1..4096
  localparam int LEAD_W     = 2;   // chip-select lead field, 0..3
  localparam int PIN_W      = 4;   // data lines d[3:0]
  localparam int LANE_CNT_W = 3;

  ////////////////////////////////////////////////////////////////////////////
  // lane mode codes and the lane counts they select
  localparam logic [1:0]            LANE_SINGLE = 2'h0;
  localparam logic [1:0]            LANE_DUAL   = 2'h1;
  localparam logic [1:0]            LANE_QUAD   = 2'h2;
  localparam logic [LANE_CNT_W-1:0] LANES_1     = 3'h1;
  localparam logic [LANE_CNT_W-1:0] LANES_2     = 3'h2;
  localparam logic [LANE_CNT_W-1:0] LANES_4     = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // timing counts and reset values
  localparam int   CS_TAIL_PERIODS = 2;     // sclk periods from last fall to release
  localparam int   SCLK_IDLE_HI    = 1;     // high phase length when divide setting is 0
  localparam logic CS_INACTIVE     = 1'h1;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_LEAD  = 4'h2,
    ST_SHIFT = 4'h4,
    ST_TAIL  = 4'h8
  } state_t;

endpackage : qspi_read_pkg

// >>> verilog/qspi_word_fifo.sv
// file: word buffer between the serial engine and the reader
`timescale 1ns/1ps
module qspi_word_fifo #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  // filling side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // draining side
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);

  localparam int PW  = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wrPtr;
    logic [PW-1:0]               rdPtr;
    logic [CNW-1:0]              count;
    logic                        valid;
    logic [WIDTH-1:0]            head;
  } fifo_t;

  fifo_t s;
  fifo_t next_s;
  logic  push;
  logic  pop;

  assign inReady  = (s.count != CNW'(DEPTH));
  assign outValid = s.valid;
  assign outData  = s.head;

  always_comb begin
    next_s = s;
    push   = inValid && inReady;
    pop    = outValid && outReady;
    if (push) begin
      next_s.mem[s.wrPtr] = inData;
      next_s.wrPtr = (s.wrPtr == PW'(DEPTH - 1)) ? '0 : s.wrPtr + PW'(1);
    end
    if (pop) begin
      next_s.rdPtr = (s.rdPtr == PW'(DEPTH - 1)) ? '0 : s.rdPtr + PW'(1);
    end
    if (push && !pop) begin
      next_s.count = s.count + CNW'(1);
    end else if (pop && !push) begin
      next_s.count = s.count - CNW'(1);
    end
    // head and valid registered so the reader sees flip-flop outputs
    next_s.valid = (next_s.count != '0);
    next_s.head  = next_s.mem[next_s.rdPtr];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else if (clkEn) begin
      s <= next_s;
    end
  end

endmodule : qspi_word_fifo

// >>> verilog/quad_spi_read_master.sv
// file: quad serial read master with clock divider, lead and tail timing
//
// Notes on behaviour
// - clock mode 0 only, sclk idles low
// - incoming data sampled at sclk falling edge
// - zero or odd divide gives 50 percent duty
// - even divide D: high lasts D/2 cycles, low D/2+1
// - cs leads first fall by field+1 periods
// - cs released two periods after last fall
// - first bit on d1 one period early
// - master only: drives sclk and cs
// - word length programmable 1 to 128 bits
// - frame length programmable 1 to 4096 words
// - cs lead delay field spans 0 to 3
`timescale 1ns/1ps
module quad_spi_read_master
  import qspi_read_pkg::*;
#(
  parameter int DIV_W      = 8,
  parameter int WORD_W     = 128,
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 clkEn,
  // control
  input  wire logic                 start,
  input  wire logic [DIV_W-1:0]     clockDivideSetting,
  input  wire logic [LEAD_W-1:0]    csLeadDelayField,
  input  wire logic [1:0]           laneMode,
  input  wire logic [WLEN_W-1:0]    wordLength,
  input  wire logic [NWORD_W-1:0]   frameWords,
  input  wire logic [CMD_W-1:0]     cmdWord,
  input  wire logic [CMD_CNT_W-1:0] cmdBits,
  input  wire logic                 wordIrqEn,
  input  wire logic                 frameIrqEn,
  // status
  output logic                      busy,
  output logic                      wordIrq,
  output logic                      frameIrq,
  // read words
  output logic      [WORD_W-1:0]    rdData,
  output logic                      rdValid,
  input  wire logic                 rdReady,
  // flash pins
  output logic                      sclk,
  output logic                      csN,
  output logic                      d1Out,
  output logic                      d1Oe,
  input  wire logic [PIN_W-1:0]     dIn
);
  localparam int CW = DIV_W + 2;
  typedef struct packed {
    state_t                st;
    logic                  sclk;
    logic                  csN;
    logic                  d1Out;
    logic                  d1Oe;
    logic                  busy;
    logic                  wordIrq;
    logic                  frameIrq;
    logic [CW-1:0]         cnt;
    logic [DIV_W-1:0]      div;
    logic [LEAD_W-1:0]     leadCfg;
    logic [LEAD_W-1:0]     leadLeft;
    logic [LANE_CNT_W-1:0] lanes;
    logic [CMD_CNT_W-1:0]  cmdLeft;
    logic [CMD_W-1:0]      cmd;
    logic [WLEN_W:0]       wlen;
    logic [WLEN_W:0]       bitsLeft;
    logic [NWORD_W:0]      nw;
    logic [NWORD_W:0]      wordsLeft;
    logic [WORD_W-1:0]     rx;
    logic                  pushV;
    logic [WORD_W-1:0]     pushD;
    logic [PIN_W-1:0]      syn1;
    logic [PIN_W-1:0]      syn2;
    logic [PIN_W-1:0]      syn3;
    logic [PIN_W-1:0]      din;
  } master_t;
  master_t           s;
  master_t           next_s;
  logic              fifoReady;
  logic              wordEv;
  logic              stall;
  logic [CW-1:0]     hiN;
  logic [CW-1:0]     loN;
  logic [CW-1:0]     period;
  logic [CMD_W-1:0]  cmdAligned;
  logic [WORD_W-1:0] rxNext;
  assign sclk     = s.sclk;
  assign csN      = s.csN;
  assign d1Out    = s.d1Out;
  assign d1Oe     = s.d1Oe;
  assign busy     = s.busy;
  assign wordIrq  = s.wordIrq;
  assign frameIrq = s.frameIrq;
  ////////////////////////////////////////////////////////////////////////////
  // divider phases: an even setting cannot split D+1 evenly, so low takes the spare cycle
  always_comb begin
    if (s.div == '0) begin
      hiN = CW'(SCLK_IDLE_HI);
      loN = CW'(SCLK_IDLE_HI);
    end else if (s.div[0]) begin
      hiN = (CW'(s.div) + CW'(1)) >> 1;
      loN = hiN;
    end else begin
      hiN = CW'(s.div) >> 1;
      loN = CW'(s.div) + CW'(1) - hiN;
    end
    period = hiN + loN;
  end
  assign cmdAligned = cmdWord << (CMD_CNT_W'(CMD_W) - cmdBits);
  always_comb begin
    unique case (s.lanes)
      LANES_4: rxNext = {s.rx[WORD_W-5:0], s.din};
      LANES_2: rxNext = {s.rx[WORD_W-3:0], s.din[1:0]};
      default: rxNext = {s.rx[WORD_W-2:0], s.din[0]};
    endcase
  end
  // hold the clock low before a word-completing fall while the last word waits
  assign stall = (s.cmdLeft == '0) && (s.bitsLeft <= (WLEN_W+1)'(s.lanes)) && s.pushV;
  ////////////////////////////////////////////////////////////////////////////
  // engine
  always_comb begin
    next_s          = s;
    wordEv          = 1'b0;
    next_s.wordIrq  = 1'b0;
    next_s.frameIrq = 1'b0;
    // first stage feeds only the second; a change counts when stages two and three agree
    next_s.syn1 = dIn;
    next_s.syn2 = s.syn1;
    next_s.syn3 = s.syn2;
    if (s.syn2 == s.syn3) begin
      next_s.din = s.syn3;
    end
    if (s.pushV && fifoReady) begin
      next_s.pushV = 1'b0;
    end
    unique case (s.st)
      ST_IDLE: begin
        next_s.sclk = 1'b0;
        next_s.csN  = CS_INACTIVE;
        if (start) begin
          next_s.div       = clockDivideSetting;
          next_s.leadCfg   = csLeadDelayField;
          next_s.leadLeft  = csLeadDelayField;
          next_s.cmd       = cmdAligned;
          next_s.cmdLeft   = cmdBits;
          next_s.wlen      = {1'b0, wordLength} + (WLEN_W+1)'(1);
          next_s.bitsLeft  = {1'b0, wordLength} + (WLEN_W+1)'(1);
          next_s.nw        = {1'b0, frameWords} + (NWORD_W+1)'(1);
          next_s.wordsLeft = {1'b0, frameWords} + (NWORD_W+1)'(1);
          unique case (laneMode)
            LANE_DUAL: next_s.lanes = LANES_2;
            LANE_QUAD: next_s.lanes = LANES_4;
            default:   next_s.lanes = LANES_1;
          endcase
          next_s.csN  = 1'b0;
          next_s.busy = 1'b1;
          next_s.cnt  = '0;
          if (csLeadDelayField == '0) begin
            next_s.st    = ST_SHIFT;
            next_s.d1Oe  = (cmdBits != '0);
            next_s.d1Out = cmdAligned[CMD_W-1];
          end else begin
            next_s.st = ST_LEAD;
          end
        end
      end
      ST_LEAD: begin
        next_s.cnt = s.cnt + CW'(1);
        if (s.cnt == period - CW'(1)) begin
          next_s.cnt = '0;
          if (s.leadLeft == LEAD_W'(1)) begin
            next_s.st    = ST_SHIFT;
            next_s.d1Oe  = (s.cmdLeft != '0);
            next_s.d1Out = s.cmd[CMD_W-1];
          end else begin
            next_s.leadLeft = s.leadLeft - LEAD_W'(1);
          end
        end
      end
      ST_SHIFT: begin
        if (!s.sclk) begin
          if (s.cnt != loN - CW'(1)) begin
            next_s.cnt = s.cnt + CW'(1);
          end else if (!stall) begin
            next_s.sclk = 1'b1;
            next_s.cnt  = '0;
          end
        end else if (s.cnt != hiN - CW'(1)) begin
          next_s.cnt = s.cnt + CW'(1);
        end else begin
          next_s.sclk = 1'b0;
          next_s.cnt  = '0;
          if (s.cmdLeft != '0) begin
            // outgoing bits change on the falling edge
            next_s.cmdLeft = s.cmdLeft - CMD_CNT_W'(1);
            next_s.cmd     = s.cmd << 1;
            next_s.d1Out   = s.cmd[CMD_W-2];
            if (s.cmdLeft == CMD_CNT_W'(1)) begin
              next_s.d1Oe = 1'b0;
            end
          end else begin
            next_s.rx       = rxNext;
            next_s.bitsLeft = s.bitsLeft - (WLEN_W+1)'(s.lanes);
            if (s.bitsLeft <= (WLEN_W+1)'(s.lanes)) begin
              wordEv          = 1'b1;
              next_s.pushV    = 1'b1;
              next_s.pushD    = rxNext;
              next_s.rx       = '0; // no stale bits above a short word
              next_s.wordIrq  = wordIrqEn;
              next_s.bitsLeft = s.wlen;
              if (s.wordsLeft == (NWORD_W+1)'(1)) begin
                next_s.st = ST_TAIL;
              end else begin
                next_s.wordsLeft = s.wordsLeft - (NWORD_W+1)'(1);
              end
            end
          end
        end
      end
      ST_TAIL: begin
        next_s.cnt  = s.cnt + CW'(1);
        next_s.d1Oe = 1'b0;
        if (s.cnt == CW'(CS_TAIL_PERIODS) * period - CW'(1)) begin
          next_s.csN      = CS_INACTIVE;
          next_s.busy     = 1'b0;
          next_s.frameIrq = frameIrqEn;
          next_s.st       = ST_IDLE;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s     <= '0;
      s.st  <= ST_IDLE;
      s.csN <= CS_INACTIVE;
    end else if (clkEn) begin
      s <= next_s;
    end
  end
  qspi_word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) wordFifo (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .inValid  (s.pushV),
    .inData   (s.pushD),
    .inReady  (fifoReady),
    .outValid (rdValid),
    .outData  (rdData),
    .outReady (rdReady)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks and the counters they read
  logic [CW+1:0]    hiRun;
  logic [CW+1:0]    leadRun;
  logic [CW+1:0]    oeRun;
  logic [CW+1:0]    sinceFall;
  logic [NWORD_W:0] wordsSeen;
  logic             sclkQ;
  logic             seenFall;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hiRun     <= '0;
      leadRun   <= '0;
      oeRun     <= '0;
      sinceFall <= '0;
      wordsSeen <= '0;
      sclkQ     <= 1'b0;
      seenFall  <= 1'b0;
    end else if (clkEn) begin
      sclkQ     <= s.sclk;
      hiRun     <= s.sclk ? hiRun + (CW+2)'(1) : '0;
      oeRun     <= s.d1Oe ? oeRun + (CW+2)'(1) : '0;
      sinceFall <= (sclkQ && !s.sclk) ? (CW+2)'(1) : sinceFall + (CW+2)'(1);
      seenFall  <= s.csN ? 1'b0 : (seenFall || (sclkQ && !s.sclk));
      leadRun   <= s.csN ? '0 : (seenFall ? leadRun : leadRun + (CW+2)'(1));
      wordsSeen <= s.csN ? '0 : wordsSeen + (NWORD_W+1)'(wordEv);
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence firstFall;
    $fell(s.sclk) && !seenFall;
  endsequence

  sequence frameEnd;
    $rose(s.csN);
  endsequence

  idle_low_a: assert property (s.csN |-> !s.sclk)
    else $error("sclk not low while deselected");
  master_only_a: assert property ($rose(s.sclk) |-> !s.csN && s.busy)
    else $error("sclk toggled outside a frame");
  sample_fall_a: assert property ($changed(s.rx) |-> $fell(s.sclk))
    else $error("data captured away from a falling edge");
  duty_odd_a: assert property ($fell(s.sclk) && s.div[0] |->
      2 * int'(hiRun) == int'(s.div) + 1)
    else $error("odd divide high phase not half the period");
  duty_even_a: assert property ($fell(s.sclk) && !s.div[0] && s.div != '0 |->
      2 * int'(hiRun) == int'(s.div))
    else $error("even divide high phase wrong");
  lead_time_a: assert property (firstFall |->
      int'(leadRun) == (int'(s.leadCfg) + 1) * int'(period))
    else $error("chip select lead time wrong");
  first_bit_a: assert property (firstFall ##0 $past(s.d1Oe) |->
      int'(oeRun) == int'(period))
    else $error("first d1 bit not one period before first fall");
  tail_time_a: assert property (frameEnd |->
      int'(sinceFall) == CS_TAIL_PERIODS * int'(period))
    else $error("chip select release time wrong");
  frame_words_a: assert property (frameEnd |-> int'(wordsSeen) == int'(s.nw))
    else $error("frame word count wrong");
  word_irq_a: assert property (@(posedge ref_clk) disable iff (!rst_n || !clkEn)
      wordEv |=> s.wordIrq == $past(wordIrqEn) ##1 !s.wordIrq)
    else $error("word interrupt pulse wrong");

endmodule : quad_spi_read_master
